// *** hw/i2cee_pkg.sv ***
// constants, states and pin bundle of the two-wire eeprom slave
// assumes one system clock, much faster than the bus clock
package i2cee_pkg;

    localparam int MEM_ADDR_W = 9;
    localparam int PAGE_BITS = 4;
    localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam int WR_CYCLES_DEF = 500000;
    localparam int SYNC_STAGES = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_RACK = 3'b100,
        ST_BUSY = 3'b101
    } i2cee_state_t;

    typedef enum logic [1:0] {
        K_DEV  = 2'b00,
        K_WORD = 2'b01,
        K_DATA = 2'b10
    } i2cee_kind_t;

    typedef struct packed {
        logic scl;
        logic sda;
        logic write_protect;
        logic strap_addr_bit2;
        logic strap_addr_bit1;
        logic strap_addr_bit0;
    } i2cee_pins_t;

endpackage

// *** hw/i2cee_sync.sv ***
// two-stage synchroniser for a bundle of asynchronous pins
// assumes the inputs are quasi-static levels between bus edges
`timescale 1ns/1ns
module i2cee_sync #(
    parameter int WIDTH = 6
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // pins
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    meta[g] <= 1'b1;
                    synced[g] <= 1'b1;
                end else begin
                    meta[g] <= raw[g];
                    synced[g] <= meta[g];
                end
            end
        end
    endgenerate
endmodule

// *** hw/i2cee_top.sv ***
// slave side of a byte-addressed two-wire eeprom with upper-half write protect
// assumes scl and sda come from an external master; clk_sys oversamples scl
//
// Functional notes
// - write protect high blocks writes to the upper half of the array.
// - write protect low or open: all accesses behave as unprotected.
// - write protect sampled once, at the scl fall before the first data byte.
// - protected write: no ack on the data byte, whole write discarded.
// - every storage byte starts erased at ff.
// - slave address with direction 1 reads at the current pointer.
// - read: ack address, shift out byte, release, await master ack.
// - master no-ack then stop ends the session, back to standby.
// - after dummy write and repeated start, send byte at loaded address.
// - each master ack on a read byte fetches the next location.
// - read pointer increments over the whole array, wrapping to zero.
// - slave address is 1010, three strap or high address bits, direction.
// - ack by pulling sda low in ninth clock; release it after read data.
// - during internal write cycle sda released, all requests ignored.
`timescale 1ns/1ns
module i2cee_top
    import i2cee_pkg::*;
#(
    parameter int ADDR_W = MEM_ADDR_W,
    parameter int WR_CYCLES = WR_CYCLES_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // two-wire bus, sda open drain
    input wire logic scl,
    input wire logic sda,
    output logic sda_level,
    output logic sda_oe,
    // straps and protection
    input wire logic write_protect,
    input wire logic strap_addr_bit2,
    input wire logic strap_addr_bit1,
    input wire logic strap_addr_bit0
);
    ////////////////////////////////////////////////////////////////////////
    i2cee_pins_t pin_raw;
    i2cee_pins_t pin;
    logic [$bits(i2cee_pins_t)-1:0] pin_vec;
    logic scl_prev;
    logic sda_prev;
    i2cee_state_t state;
    i2cee_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic rw;
    logic prot;
    logic mack;
    logic wrote;
    logic [ADDR_W-1:0] ptr;
    logic [19:0] busy_cnt;
    // powers up erased; declared with its start value so only the write port drives it later
    logic [7:0] mem [0:(1<<ADDR_W)-1] = '{default: ERASED_BYTE};

    assign pin_raw = '{scl: scl, sda: sda, write_protect: write_protect,
                       strap_addr_bit2: strap_addr_bit2, strap_addr_bit1: strap_addr_bit1,
                       strap_addr_bit0: strap_addr_bit0};
    assign pin = i2cee_pins_t'(pin_vec);

    i2cee_sync #(.WIDTH($bits(i2cee_pins_t))) u_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .raw(pin_raw),
        .synced(pin_vec)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus events and decodes
    wire scl_rise = pin.scl && !scl_prev;
    wire scl_fall = !pin.scl && scl_prev;
    wire start_cond = pin.scl && scl_prev && sda_prev && !pin.sda;
    wire stop_cond = pin.scl && scl_prev && !sda_prev && pin.sda;
    wire rx_done = (state == ST_RX) && scl_fall && (cnt == BITS_PER_BYTE);
    // bit 1 is the high array bit on the large array, strap 0 otherwise
    wire bit1_ok = (ADDR_W > 8) ? 1'b1 : (sh[1] == pin.strap_addr_bit0);
    wire dev_match = (sh[7:4] == DEV_TYPE_CODE) && (sh[3] == pin.strap_addr_bit2)
                     && (sh[2] == pin.strap_addr_bit1) && bit1_ok;
    wire ack_start = scl_fall && (state == ST_ACK);
    wire wp_strobe = ack_start && (kind == K_WORD) && !rw;
    wire tx_load = (ack_start && rw) || (scl_fall && (state == ST_RACK) && mack);
    wire mem_we = rx_done && (kind == K_DATA) && !prot;
    wire [7:0] mem_rd = mem[ptr];
    wire busy_done = (busy_cnt == 20'h00001);
    wire [ADDR_W-1:0] ptr_page_inc = {ptr[ADDR_W-1:PAGE_BITS], ptr[PAGE_BITS-1:0] + 1'b1};

    always_ff @(posedge clk_sys) begin
        if (mem_we) begin
            mem[ptr] <= sh;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= pin.scl;
            sda_prev <= pin.sda;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sh <= 8'h00;
            cnt <= 4'h0;
        end else if (start_cond || ack_start || (scl_fall && state == ST_RACK)) begin
            cnt <= 4'h0;
        end else if (state == ST_RX && scl_rise) begin
            sh <= {sh[6:0], pin.sda};
            cnt <= cnt + 4'h1;
        end else if (state == ST_TX && scl_fall) begin
            cnt <= cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            prot <= 1'b0;
        end else if (wp_strobe) begin
            // single strobe per write; a lower-half target is never blocked
            prot <= pin.write_protect && ptr[ADDR_W-1];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mack <= 1'b0;
        end else if (state == ST_RACK && scl_rise) begin
            mack <= !pin.sda;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ptr <= '0;
        end else if (tx_load) begin
            ptr <= ptr + 1'b1;
        end else if (mem_we) begin
            ptr <= ptr_page_inc;
        end else if (rx_done && kind == K_WORD) begin
            ptr[7:0] <= sh;
        end else if (rx_done && kind == K_DEV && dev_match && !sh[0] && ADDR_W > 8) begin
            ptr[ADDR_W-1] <= sh[1];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tx <= 8'h00;
        end else if (tx_load) begin
            tx <= mem_rd;
        end else if (state == ST_TX && scl_fall) begin
            tx <= {tx[6:0], 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer; start and stop are seen in every state but busy
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            kind <= K_DEV;
            rw <= 1'b0;
            wrote <= 1'b0;
            busy_cnt <= 20'h00000;
        end else if (state == ST_BUSY) begin
            // requests are ignored until the array write ends
            busy_cnt <= busy_cnt - 20'h00001;
            if (busy_done) begin
                state <= ST_IDLE;
            end
        end else if (stop_cond) begin
            wrote <= 1'b0;
            busy_cnt <= 20'(WR_CYCLES);
            state <= wrote ? ST_BUSY : ST_IDLE;
        end else if (start_cond) begin
            state <= ST_RX;
            kind <= K_DEV;
        end else if (rx_done) begin
            if (kind == K_DEV) begin
                rw <= sh[0];
                state <= dev_match ? ST_ACK : ST_IDLE;
            end else if (kind == K_DATA && prot) begin
                state <= ST_IDLE;
            end else begin
                wrote <= wrote || (kind == K_DATA);
                state <= ST_ACK;
            end
        end else if (ack_start) begin
            if (rw) begin
                state <= ST_TX;
            end else begin
                kind <= (kind == K_DEV) ? K_WORD : K_DATA;
                state <= ST_RX;
            end
        end else if (state == ST_TX && scl_fall && cnt == LAST_TX_BIT) begin
            state <= ST_RACK;
        end else if (state == ST_RACK && scl_fall) begin
            state <= mack ? ST_TX : ST_IDLE;
        end
    end

    // the ack is driven from the fall after bit 8 to the fall after bit 9
    wire next_oe_ack = (rx_done && (kind != K_DATA || !prot) && (kind != K_DEV || dev_match));
    wire next_oe_tx = tx_load ? !mem_rd[7] : !tx[6];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sda_oe <= 1'b0;
            sda_level <= 1'b0;
        end else if (state == ST_BUSY || start_cond || stop_cond) begin
            sda_oe <= 1'b0;
        end else if (rx_done) begin
            sda_oe <= next_oe_ack;
        end else if (tx_load || (state == ST_TX && scl_fall && cnt != LAST_TX_BIT)) begin
            sda_oe <= next_oe_tx;
        end else if (scl_fall && (state == ST_ACK || state == ST_TX)) begin
            sda_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_nack_slot;
        (state == ST_RACK) && scl_fall && !mack;
    endsequence

    sequence s_data_decided;
        rx_done && (kind == K_DATA);
    endsequence

    a_upper_blocked: assert property (wp_strobe && pin.write_protect && ptr[ADDR_W-1] |=> prot)
        else $error("protected write reached the array");
    a_wp_low_free: assert property (wp_strobe && !pin.write_protect |=> !prot)
        else $error("low write protect still blocked the write");
    a_wp_strobe_only: assert property ($changed(prot) |-> $past(wp_strobe))
        else $error("protect flag moved outside its strobe");
    a_wp_refuse_nack: assert property (s_data_decided ##0 prot |=> !sda_oe && state == ST_IDLE)
        else $error("protected data byte was acknowledged");
    a_lower_ack: assert property (s_data_decided ##0 !prot |=> sda_oe ##1 wrote)
        else $error("unprotected data byte not acknowledged");
    a_read_load: assert property (tx_load |=> tx == $past(mem_rd) && state == ST_TX)
        else $error("read byte not loaded from pointer");
    a_read_wrap: assert property (tx_load && (&ptr) |=> ptr == '0)
        else $error("read pointer did not wrap to zero");
    a_nack_idle: assert property (s_nack_slot |=> state == ST_IDLE && !sda_oe)
        else $error("no-ack did not end the read");
    a_dev_ack: assert property (rx_done && kind == K_DEV && dev_match |=> sda_oe [*1] ##1 state == ST_ACK)
        else $error("matching address not acknowledged");
    a_busy_quiet: assert property (state == ST_BUSY && !busy_done |=> state == ST_BUSY && !sda_oe)
        else $error("request answered during write cycle");
endmodule

// *** tb/i2cee_master.sv ***
// behavioural two-wire bus master driving scl and pulling sda low
// assumes a pull-up on sda; the bench resolves the wire from all pullers
`timescale 1ns/1ns
module i2cee_master (
    // bus
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // serves both as first start from idle and as repeated start with scl low
    task automatic start();
        sda_pull = 1'b0;
        #30 scl = 1'b1;
        #30 sda_pull = 1'b1;
        #30 scl = 1'b0;
        #30;
    endtask

    // one 125 ns scl period; data changes only while scl is low
    task automatic clk_bit(input logic b, output logic r);
        sda_pull = ~b;
        #32 scl = 1'b1;
        #31 r = sda;
        #31 scl = 1'b0;
        #31;
    endtask

    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(d[i], r);
        end
        clk_bit(1'b1, r);
        ack = ~r;
    endtask

    // more high acks the byte to ask for the next one, low ends the read
    task automatic get_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, r);
            d[i] = r;
        end
        clk_bit(~more, r);
    endtask

    task automatic stop();
        sda_pull = 1'b1;
        #32 scl = 1'b1;
        #31 sda_pull = 1'b0;
        #62;
    endtask
endmodule

// *** tb/test_i2cee_top.sv ***
// self-checking bench for the two-wire eeprom slave
// assumes the master model in i2cee_master.sv and a pulled-up sda wire
`timescale 1ns/1ns
module test_i2cee_top
    import i2cee_pkg::*;
;
    localparam int WR_SIM = 40;
    logic clk_sys, rst, scl, sda, sda_level, sda_oe, sda_pull, write_protect;
    logic strap_addr_bit2, strap_addr_bit1, strap_addr_bit0;
    int n_fail, compares, cycles;

    // open drain: low when anyone pulls, otherwise the pull-up wins
    assign sda = ~((sda_oe & ~sda_level) | sda_pull);

    i2cee_top #(.WR_CYCLES(WR_SIM)) u_dut (.clk_sys(clk_sys), .rst(rst), .scl(scl), .sda(sda),
        .sda_level(sda_level), .sda_oe(sda_oe), .write_protect(write_protect),
        .strap_addr_bit2(strap_addr_bit2), .strap_addr_bit1(strap_addr_bit1),
        .strap_addr_bit0(strap_addr_bit0));
    i2cee_master u_bus (.scl(scl), .sda_pull(sda_pull), .sda(sda));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // straps 2 and 1 are held at 1 0, so only that pattern may match
    function automatic logic [7:0] dev(input logic hi, input logic rw);
        return {DEV_TYPE_CODE, 2'b10, hi, rw};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    task automatic addr_phase(input logic [8:0] a);
        logic ack;
        u_bus.start();
        u_bus.put_byte(dev(a[8], 1'b0), ack);
        check("device ack", {7'h0, ack}, 8'h01);
        u_bus.put_byte(a[7:0], ack);
        check("word ack", {7'h0, ack}, 8'h01);
    endtask

    // exp holds up to eight bytes, first one in the top byte
    task automatic rd_from(input logic [8:0] a, input int n, input logic [63:0] exp);
        logic ack;
        logic [7:0] d;
        addr_phase(a);
        u_bus.start();
        u_bus.put_byte(dev(1'b0, 1'b1), ack);
        check("read address ack", {7'h0, ack}, 8'h01);
        for (int i = 0; i < n; i++) begin
            u_bus.get_byte(i < n - 1, d);
            check("read data", d, exp[63 - 8 * i -: 8]);
        end
        u_bus.stop();
    endtask

    task automatic wait_write();
        repeat (WR_SIM + 20) @(negedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_erased();
        logic ack;
        logic [7:0] d;
        u_bus.start();
        u_bus.put_byte(dev(1'b0, 1'b1), ack);
        check("current read ack", {7'h0, ack}, 8'h01);
        u_bus.get_byte(1'b0, d);
        check("erased byte", d, ERASED_BYTE);
        u_bus.stop();
        check("idle release", {7'h0, sda_oe}, 8'h00);
        check("drive level", {7'h0, sda_level}, 8'h00);
        u_bus.start();
        u_bus.put_byte({DEV_TYPE_CODE, 2'b11, 1'b0, 1'b1}, ack);
        check("foreign address ack", {7'h0, ack}, 8'h00);
        u_bus.stop();
    endtask

    task automatic t_protect();
        logic ack;
        @(negedge clk_sys);
        write_protect = 1'b1;
        addr_phase(9'h005);
        u_bus.put_byte(8'h3c, ack);
        check("lower write ack", {7'h0, ack}, 8'h01);
        u_bus.stop();
        wait_write();
        addr_phase(9'h105);
        u_bus.put_byte(8'h5a, ack);
        check("upper write ack", {7'h0, ack}, 8'h00);
        u_bus.stop();
        // a refused write starts no write cycle, so no wait here
        rd_from(9'h105, 1, {ERASED_BYTE, 56'h0});
        rd_from(9'h005, 1, {8'h3c, 56'h0});
    endtask

    task automatic t_late_wp_busy();
        logic ack;
        @(negedge clk_sys);
        write_protect = 1'b0;
        addr_phase(9'h1ff);
        // raised only after the strobe, so this write must still go through
        #40;
        @(negedge clk_sys);
        write_protect = 1'b1;
        u_bus.put_byte(8'ha5, ack);
        check("late protect ack", {7'h0, ack}, 8'h01);
        u_bus.stop();
        u_bus.start();
        u_bus.put_byte(dev(1'b0, 1'b0), ack);
        check("busy poll ack", {7'h0, ack}, 8'h00);
        u_bus.stop();
        wait_write();
        @(negedge clk_sys);
        write_protect = 1'b0;
    endtask

    task automatic t_seq_wrap();
        rd_from(9'h1fe, 8, 64'hffa5ffffffffff3c);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        write_protect = 1'b0;
        strap_addr_bit2 = 1'b1;
        strap_addr_bit1 = 1'b0;
        strap_addr_bit0 = 1'b1;
        n_fail = 0;
        compares = 0;
        cycles = 0;
        repeat (6) @(negedge clk_sys);
        rst = 1'b0;
        repeat (6) @(negedge clk_sys);
        t_erased();
        t_protect();
        t_late_wp_busy();
        t_seq_wrap();
        results();
    end
endmodule
